//--- hdl/rail_seq_pkg.sv
/*
  Constants for the rail startup and shutdown sequencer: delays, clock
  rate and derived cycle counts. Assumes a single 10 MHz clock.
*/
package rail_seq_pkg;
  // Clock rate in kHz, so that a microsecond figure maps to cycles
  localparam int unsigned CLK_KHZ = 10000;
  localparam int unsigned CYC_PER_US = CLK_KHZ / 1000;
  // Delays in microseconds as specified
  localparam int unsigned KEEP_ALIVE_DLY_US = 400;
  localparam int unsigned HIGH_IO_DLY_US = 32000;
  localparam int unsigned CHAIN_DLY_US = 1000;
  localparam int unsigned SEQ_DLY_US = 0;
  localparam int unsigned AUX_DLY_US = 1000;
  localparam int unsigned SYSTEM_DLY_US = 2000;
  // Long press and reset release, in milliseconds
  localparam int unsigned LONG_PRESS_MS = 4000;
  localparam int unsigned RESET_DLY_MS = 40;
  // Derived cycle counts (least times, exact at this rate)
  localparam int unsigned KEEP_ALIVE_CYC = KEEP_ALIVE_DLY_US * CYC_PER_US;
  localparam int unsigned HIGH_IO_CYC = HIGH_IO_DLY_US * CYC_PER_US;
  localparam int unsigned CHAIN_CYC = CHAIN_DLY_US * CYC_PER_US;
  localparam int unsigned SEQ_CYC = SEQ_DLY_US * CYC_PER_US;
  localparam int unsigned AUX_CYC = AUX_DLY_US * CYC_PER_US;
  localparam int unsigned SYSTEM_CYC = SYSTEM_DLY_US * CYC_PER_US;
  localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * 1000 * CYC_PER_US;
  localparam int unsigned RESET_CYC = RESET_DLY_MS * 1000 * CYC_PER_US;
  // Counter width that covers every count above
  localparam int unsigned CNT_W = 32;
  // Number of spare rails left off in this option
  localparam int unsigned SPARE_N = 4;
endpackage

//--- hdl/rail_delay.sv
/*
  One start-delay stage: output rises once the trigger has stood high
  for DELAY cycles and falls at once with the trigger.
  Assumes trigger is on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rail_delay #(
  parameter int unsigned DELAY = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic trigger,
  output logic enable
);
  import rail_seq_pkg::*;
  logic [CNT_W-1:0] count; // Cycles the trigger has stood high
  initial begin
    if (DELAY >= (64'd1 << CNT_W)) begin
      $error("rail_delay DELAY too large");
    end
  end
  // Count while triggered; zero delay still costs one register stage
  always_ff @(posedge clk) begin
    if (!nrst || clear || !trigger) begin
      count <= '0;
      enable <= 1'b0;
    end else if (count >= CNT_W'(DELAY)) begin
      enable <= 1'b1;
    end else begin
      count <= count + CNT_W'(1);
    end
  end
endmodule // rail_delay
`default_nettype wire

//--- hdl/rail_startup_shutdown_sequencer.sv
/*
  Startup and shutdown sequencer for the rails of factory_option_b, with
  push-button handling and the active-low processor reset.
  Assumes "in regulation" of a rail is taken as its enable plus its own
  delay; pins arrive asynchronously and pass three flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Keep-alive rail on 400us after valid supply
// - Wake pin high starts high I/O after 32ms
// - Chain rails follow each other after 1ms; sequencing rail after 0
// - Both auxiliary rails on, each after 1ms
// - Power-hold latches the chain on
// - System rail from hold AND enable, 2ms
// - System rail off when enable or hold low
// - Hold low with wake low ends chain
// - Press over 4s powers all outputs down
// - Short press pulses processor reset low
// - Release after long press restarts sequence
// - Reset released 40ms after sequencing rail
// - Spare rails stay off
module rail_startup_shutdown_sequencer #(
  parameter int unsigned HIGH_IO_CYCLES = rail_seq_pkg::HIGH_IO_CYC,
  parameter int unsigned LONG_PRESS_CYCLES = rail_seq_pkg::LONG_PRESS_CYC,
  parameter int unsigned RESET_CYCLES = rail_seq_pkg::RESET_CYC,
  parameter int unsigned CHAIN_CYCLES = rail_seq_pkg::CHAIN_CYC,
  parameter int unsigned SYSTEM_CYCLES = rail_seq_pkg::SYSTEM_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic input_supply_valid,
  input wire logic wake_trigger_pin,
  input wire logic power_hold_in,
  input wire logic power_enable_in,
  input wire logic push_button_n,
  output logic keep_alive_rail,
  output logic high_io_rail,
  output logic memory_rail,
  output logic core_rail,
  output logic io_rail,
  output logic sequencing_rail,
  output logic aux_rail_a,
  output logic aux_rail_b,
  output logic system_rail,
  output logic [rail_seq_pkg::SPARE_N-1:0] spare_rails,
  output logic processor_reset_n
);
  import rail_seq_pkg::*;

  initial begin
    if (LONG_PRESS_CYCLES < 2 || RESET_CYCLES < 1 || HIGH_IO_CYCLES < 1) begin
      $error("sequencer counts must be at least one cycle");
    end
  end

  // Pin synchronisers: three stages each, change taken when 2 and 3 agree
  logic [4:0] sync1; // First stage, read only by sync2
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pins; // Filtered pin levels
  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Stages reset to the idle pin levels, as the filtered levels do.
      // Otherwise the first edges after reset show a false press and a false lockout.
      sync1 <= 5'h11;
      sync2 <= 5'h11;
      sync3 <= 5'h11;
      pins <= 5'h11;
    end else begin
      sync1 <= {push_button_n, power_enable_in, power_hold_in,
                wake_trigger_pin, input_supply_valid};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 5; i++) begin
        if (sync2[i] == sync3[i]) begin
          pins[i] <= sync3[i];
        end
      end
    end
  end

  logic supply_ok; // Undervoltage lockout released
  logic wake; // Wake trigger level
  logic hold; // Power-hold level
  logic pen; // Power-enable level
  logic button; // Push button pressed
  assign supply_ok = pins[0];
  assign wake = pins[1];
  assign hold = pins[2];
  assign pen = pins[3];
  assign button = !pins[4];

  logic clear; // Lockout (supply not valid) clears the sequencer
  assign clear = !supply_ok;

  // Push-button state machine
  typedef enum logic [3:0] {
    BTN_IDLE = 4'h1,
    BTN_PRESS = 4'h2,
    BTN_LONG = 4'h4,
    BTN_RESET = 4'h8
  } btn_state_t;
  btn_state_t btn_state;
  logic [CNT_W-1:0] press_cnt; // Shared timebase for press and reset pulse
  logic long_off; // Outputs held down by long press

  // Press timing: short press resets, long press powers down
  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      btn_state <= BTN_IDLE;
      press_cnt <= '0;
    end else begin
      unique case (btn_state)
        BTN_IDLE: begin
          press_cnt <= '0;
          if (button) begin
            btn_state <= BTN_PRESS;
          end
        end
        BTN_PRESS: begin
          if (!button) begin
            // Short press: time a reset pulse
            btn_state <= BTN_RESET;
            press_cnt <= '0;
          end else if (press_cnt >= CNT_W'(LONG_PRESS_CYCLES)) begin
            btn_state <= BTN_LONG;
          end else begin
            press_cnt <= press_cnt + CNT_W'(1);
          end
        end
        BTN_LONG: begin
          // Stay down until release, then restart from the top
          if (!button) begin
            btn_state <= BTN_IDLE;
          end
        end
        BTN_RESET: begin
          if (press_cnt >= CNT_W'(RESET_CYCLES)) begin
            btn_state <= BTN_IDLE;
          end else begin
            press_cnt <= press_cnt + CNT_W'(1);
          end
        end
      endcase
    end
  end
  assign long_off = (btn_state == BTN_LONG);

  logic off; // Any cause that drops every rail
  assign off = clear || long_off;

  // Keep-alive rail: follows the valid supply after its delay
  // Lockout needs no clear here: the trigger already is the supply
  rail_delay #(
    .DELAY(KEEP_ALIVE_CYC)
  ) u_keep (
    .clk(clk),
    .nrst(nrst),
    .clear(long_off),
    .trigger(supply_ok),
    .enable(keep_alive_rail)
  );

  // Chain latch: set by hold once high I/O is up, ended by hold+wake low
  logic chain_latched;
  always_ff @(posedge clk) begin
    if (!nrst || off) begin
      chain_latched <= 1'b0;
    end else if (high_io_rail && hold) begin
      chain_latched <= 1'b1;
    end else if (!hold && !wake) begin
      chain_latched <= 1'b0;
    end
  end

  logic chain_req; // Chain requested by wake or latch
  assign chain_req = (wake || chain_latched) && !off;

  logic high_io_d, memory_d, core_d, io_d, seq_d, aux_a_d, aux_b_d, sys_d;
  // High I/O rail: first of the chain, long start delay after wake
  rail_delay #(
    .DELAY(HIGH_IO_CYCLES)
  ) u_high (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(chain_req),
    .enable(high_io_d)
  );
  // Memory rail: waits for high I/O to be in regulation
  rail_delay #(
    .DELAY(CHAIN_CYCLES)
  ) u_mem (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(high_io_d && chain_req),
    .enable(memory_d)
  );
  // Core rail: waits for the memory rail
  rail_delay #(
    .DELAY(CHAIN_CYCLES)
  ) u_core (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(memory_d && chain_req),
    .enable(core_d)
  );
  // I/O rail: waits for the core rail
  rail_delay #(
    .DELAY(CHAIN_CYCLES)
  ) u_io (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(core_d && chain_req),
    .enable(io_d)
  );
  // Sequencing rail: zero delay, still one register stage late
  rail_delay #(
    .DELAY(SEQ_CYC)
  ) u_seq (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(io_d && chain_req),
    .enable(seq_d)
  );
  // First auxiliary rail: hangs off the sequencing rail
  rail_delay #(
    .DELAY(AUX_CYC)
  ) u_aux_a (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(seq_d && chain_req),
    .enable(aux_a_d)
  );
  // Second auxiliary rail: needs the system rail and a live chain
  rail_delay #(
    .DELAY(AUX_CYC)
  ) u_aux_b (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(system_rail && chain_req),
    .enable(aux_b_d)
  );

  // System rail: AND of hold and enable, dropped at once when either falls
  rail_delay #(
    .DELAY(SYSTEM_CYCLES)
  ) u_sys (
    .clk(clk),
    .nrst(nrst),
    .clear(off),
    .trigger(hold && pen),
    .enable(sys_d)
  );

  // Reset release timer after the sequencing rail is up
  logic [CNT_W-1:0] rst_cnt;
  logic rst_release;
  always_ff @(posedge clk) begin
    if (!nrst || off || !sequencing_rail) begin
      rst_cnt <= '0;
      rst_release <= 1'b0;
    end else if (rst_cnt >= CNT_W'(RESET_CYCLES)) begin
      rst_release <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + CNT_W'(1);
    end
  end

  // Output registers; rails drop one cycle after any off cause
  always_ff @(posedge clk) begin
    if (!nrst || off) begin
      high_io_rail <= 1'b0;
      memory_rail <= 1'b0;
      core_rail <= 1'b0;
      io_rail <= 1'b0;
      sequencing_rail <= 1'b0;
      aux_rail_a <= 1'b0;
      aux_rail_b <= 1'b0;
      system_rail <= 1'b0;
    end else begin
      high_io_rail <= high_io_d && chain_req;
      memory_rail <= memory_d && chain_req;
      core_rail <= core_d && chain_req;
      io_rail <= io_d && chain_req;
      sequencing_rail <= seq_d && chain_req;
      aux_rail_a <= aux_a_d && chain_req;
      aux_rail_b <= aux_b_d && chain_req;
      system_rail <= sys_d && hold && pen;
    end
  end

  // Spare rails never enabled here; serial writes live elsewhere
  always_ff @(posedge clk) begin
    spare_rails <= '0;
  end

  // Processor reset: gated by sequencing rail, pulsed by short press
  always_ff @(posedge clk) begin
    if (!nrst || off) begin
      processor_reset_n <= 1'b0;
    end else begin
      processor_reset_n <= rst_release && sequencing_rail
                           && (btn_state != BTN_RESET);
    end
  end
endmodule // rail_startup_shutdown_sequencer
`default_nettype wire

//--- verification/rail_seq_sva.sv
/* Checker on the sequencer ports: rail order, start delays, shutdowns.
   Assumes it is bound to the top module with the same counts. */
`timescale 1ns/1ps
`default_nettype none
module rail_seq_sva #(
  parameter int unsigned HIGH_IO_CYCLES = 20,
  parameter int unsigned LONG_PRESS_CYCLES = 50,
  parameter int unsigned RESET_CYCLES = 10,
  parameter int unsigned SYSTEM_CYCLES = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic input_supply_valid,
  input wire logic wake_trigger_pin,
  input wire logic power_hold_in,
  input wire logic power_enable_in,
  input wire logic push_button_n,
  input wire logic keep_alive_rail,
  input wire logic high_io_rail,
  input wire logic memory_rail,
  input wire logic core_rail,
  input wire logic io_rail,
  input wire logic sequencing_rail,
  input wire logic aux_rail_a,
  input wire logic system_rail,
  input wire logic [rail_seq_pkg::SPARE_N-1:0] spare_rails,
  input wire logic processor_reset_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Run lengths of wake, hold with enable, sequencing rail, button
  int unsigned wcnt, ecnt, scnt, bcnt;
  always_ff @(posedge clk) begin
    wcnt <= wake_trigger_pin ? wcnt + 1 : 0;
    ecnt <= (power_hold_in && power_enable_in) ? ecnt + 1 : 0;
    scnt <= sequencing_rail ? scnt + 1 : 0;
    bcnt <= push_button_n ? 0 : bcnt + 1;
  end
  // Wake drops while the chain is latched by hold
  sequence s_drop; $fell(wake_trigger_pin); endsequence
  sequence s_latched; power_hold_in && high_io_rail; endsequence
  property p_hold; s_drop ##0 s_latched |=> high_io_rail [*8]; endproperty
  a_hold: assert property (p_hold) else $error("chain lost");
  property p_spare; spare_rails == '0; endproperty
  a_spare: assert property (p_spare) else $error("spare on");
  // Past values allow a one-cycle lag when the chain falls
  property p_order; (memory_rail |-> $past(high_io_rail))
    and (core_rail |-> $past(memory_rail)) and (io_rail |-> $past(core_rail))
    and (sequencing_rail |-> $past(io_rail)); endproperty
  a_order: assert property (p_order) else $error("rail order");
  property p_wake; $rose(high_io_rail) |-> wcnt >= HIGH_IO_CYCLES; endproperty
  a_wake: assert property (p_wake) else $error("high io early");
  property p_sys_on; $rose(system_rail) |-> ecnt >= SYSTEM_CYCLES; endproperty
  a_sys_on: assert property (p_sys_on) else $error("system early");
  property p_sys_off; $fell(power_enable_in) |-> ##[1:8] !system_rail;
  endproperty
  a_sys_off: assert property (p_sys_off) else $error("system on");
  property p_end; $fell(power_hold_in) && !wake_trigger_pin
    |-> ##[1:8] !high_io_rail; endproperty
  a_end: assert property (p_end) else $error("chain stays");
  property p_long; bcnt > LONG_PRESS_CYCLES + 8 |-> !keep_alive_rail;
  endproperty
  a_long: assert property (p_long) else $error("long press");
  property p_rst; processor_reset_n |-> $past(scnt) >= RESET_CYCLES;
  endproperty
  a_rst: assert property (p_rst) else $error("reset early");
  property p_aux; aux_rail_a |-> $past(sequencing_rail); endproperty
  a_aux: assert property (p_aux) else $error("aux early");
  property p_sup; $fell(input_supply_valid)
    |-> ##[1:8] !(keep_alive_rail || high_io_rail); endproperty
  a_sup: assert property (p_sup) else $error("supply off");
endmodule // rail_seq_sva
bind rail_startup_shutdown_sequencer rail_seq_sva #(
  .HIGH_IO_CYCLES(HIGH_IO_CYCLES), .LONG_PRESS_CYCLES(LONG_PRESS_CYCLES),
  .RESET_CYCLES(RESET_CYCLES), .SYSTEM_CYCLES(SYSTEM_CYCLES)) chk (.*);
`default_nettype wire

//--- verification/host_model.sv
/* Host side: hold pulled up from the high I/O rail, enable from host.
   Assumes commands change on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic high_io_rail,
  input wire logic let_go,
  input wire logic en_cmd,
  output logic power_hold_in,
  output logic power_enable_in
);
  // Pull-up from the rail; host pulls low to shut down
  assign power_hold_in = high_io_rail && !let_go;
  initial power_enable_in = 1'b0;
  // Host answers a cycle late, as a slow one would
  always @(posedge clk) power_enable_in <= en_cmd;
endmodule // host_model
`default_nettype wire

//--- verification/rail_startup_shutdown_sequencer_bench.sv
/* Bench: drives pins on the falling edge, checks order and delays.
   Assumes the checker bind and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rail_startup_shutdown_sequencer_bench;
  import rail_seq_pkg::*;
  // Shortened counts; expectations derive from these and from KEEP_ALIVE_CYC and AUX_CYC
  localparam int HI = 20, LP = 50, RC = 10, CC = 5, SC = 8;
  logic clk = 0, nrst = 0, input_supply_valid = 1, wake_trigger_pin = 0;
  logic push_button_n = 1, let_go = 0, en_cmd = 0;
  wire logic power_hold_in, power_enable_in, keep_alive_rail, high_io_rail;
  wire logic memory_rail, core_rail, io_rail, sequencing_rail, aux_rail_a;
  wire logic aux_rail_b, system_rail, processor_reset_n;
  wire logic [SPARE_N-1:0] spare_rails;
  wire logic [13:0] outs = {keep_alive_rail, high_io_rail, memory_rail,
    core_rail, io_rail, sequencing_rail, aux_rail_a, aux_rail_b,
    system_rail, spare_rails, processor_reset_n};
  logic [13:0] q[$], mq[$]; // Expected values and their masks
  logic [15:0] rnd = 16'h22AE; // Random state
  int err_count = 0, num_checks = 0, cyc = 0, t0, t;
  event take;
  rail_startup_shutdown_sequencer #(.HIGH_IO_CYCLES(HI),
    .LONG_PRESS_CYCLES(LP), .RESET_CYCLES(RC), .CHAIN_CYCLES(CC),
    .SYSTEM_CYCLES(SC)) DUT (.*);
  host_model host (.*);
  always #50 clk = ~clk;
  // Cycle count, also the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic note(input logic [13:0] e, input logic [13:0] m);
    q.push_back(e);
    mq.push_back(m);
    -> take;
  endtask
  task automatic cmp(input logic [13:0] e, input logic [13:0] m);
    num_checks++;
    if ((outs & m) !== e) begin
      err_count++;
      $display("BAD %0t exp %h got %h", $time, e, outs & m);
    end
  endtask
  // Delay at least lo, with 8 cycles of slack for pin sync
  task automatic cmp_n(input int d, input int lo);
    num_checks++;
    if (d < lo || d > lo + 8) begin
      err_count++;
      $display("BAD %0t exp %h got %h", $time, lo, d);
    end
  endtask
  task automatic wait_to(input int i, input logic v, input int s,
    input int lo, output int r);
    while (outs[i] !== v && cyc < s + lo + 9) @(negedge clk);
    r = cyc;
    cmp_n(r - s, lo);
  endtask
  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Monitor takes every queued note, oldest first, whenever a result is flagged
  always @(take) begin
    while (q.size() != 0) cmp(q.pop_front(), mq.pop_front());
  end
  initial begin
    repeat (8) @(negedge clk);
    note(14'h0000, 14'h3FFF);
    nrst = 1;
    wait_to(13, 1, cyc, KEEP_ALIVE_CYC, t);
    wake_trigger_pin = 1;
    wait_to(12, 1, cyc, HI, t0);
    wait_to(11, 1, t0, CC, t0);
    wait_to(10, 1, t0, CC, t0);
    wait_to(9, 1, t0, CC, t0);
    wait_to(8, 1, t0, 0, t0);
    wait_to(0, 1, t0, RC, t);
    wait_to(7, 1, t0, AUX_CYC, t);
    wake_trigger_pin = 0;
    repeat (20) @(negedge clk);
    note(14'h3F81, 14'h3FFF);
    en_cmd = 1;
    wait_to(5, 1, cyc, SC, t0);
    wait_to(6, 1, t0, AUX_CYC, t);
    note(14'h3FE1, 14'h3FFF);
    en_cmd = 0;
    wait_to(5, 0, cyc, 0, t);
    // Short presses of random length, all below the long press
    repeat (2) begin
      rnd = step(rnd);
      push_button_n = 0;
      repeat (rnd[4:0] + 4) @(negedge clk);
      push_button_n = 1;
      wait_to(0, 0, cyc, 0, t);
      wait_to(0, 1, t, RC, t);
      note(14'h3F80, 14'h3F80);
    end
    let_go = 1;
    wait_to(12, 0, cyc, 0, t);
    repeat (4) @(negedge clk);
    note(14'h2000, 14'h3FA1);
    let_go = 0;
    push_button_n = 0;
    wait_to(13, 0, cyc, LP, t);
    repeat (10) @(negedge clk);
    note(14'h0000, 14'h3FFF);
    push_button_n = 1;
    wait_to(13, 1, cyc, KEEP_ALIVE_CYC, t);
    input_supply_valid = 0;
    wait_to(13, 0, cyc, 0, t);
    repeat (10) @(negedge clk);
    stop_test();
  end
endmodule // rail_startup_shutdown_sequencer_bench
`default_nettype wire
